// ---- hdl/slcd_consts.vh ----
// Purpose: constants for the segment display controller
// Assumes: byte offsets not all multiples of four, so offsets are indices
// Notes:   byte address is four times the index
`ifndef SLCD_CONSTS_VH
`define SLCD_CONSTS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define SLCD_IDX_P3CFG   8'h9e
`define SLCD_IDX_P4CFG   8'h9f
`define SLCD_IDX_CTRL    8'ha1
`define SLCD_IDX_MODE    8'ha2
`define SLCD_IDX_SEGEN0  8'ha3
`define SLCD_IDX_WIN     8'ha4
`define SLCD_IDX_INDEX   8'ha5
`define SLCD_IDX_SEGEN1  8'ha6
`define SLCD_IDX_SEGEN2  8'ha7
`define SLCD_IDX_INTERRUPT_ENABLE_0    8'ha8
`define SLCD_IDX_SEGEN3  8'haa
`define SLCD_IDX_SEGEN4  8'hab
`define SLCD_IDX_P5CFG   8'hcf
`define SLCD_IDX_P6CFG   8'hd6
`define SLCD_IDX_P7CFG   8'hd7
`define SLCD_IDX_INTERRUPT_ENABLE_2    8'h9a
`define SLCD_IDX_IRQ2    8'hbf
// ----------------------------------------
// field positions
// ----------------------------------------
`define SLCD_CTRL_EN     7
`define SLCD_CTRL_STAT   6
`define SLCD_MODE_IDLE   7
`define SLCD_MODE_SFM    6
`define SLCD_MODE_CKS    3
`define SLCD_INTERRUPT_ENABLE_2_LCD    6
`define SLCD_IRQ2_LCD    6
// ----------------------------------------
// reset values and sizes
// ----------------------------------------
`define SLCD_RST_BYTE    8'h00
`define SLCD_BUF_DEPTH   36
`define SLCD_BUF_LAST    6'h23
`define SLCD_FRC_WIDTH   10
`endif

// ---- hdl/slcd_ctrl.v ----
// Purpose: segment display controller with AHB-Lite register slave
// Assumes: frame sources arrive as pins; ack pulse from interrupt controller
// Notes:   analog levels leave as per-pin drive codes
//
// Overview of operation
// R1: disabled with idle drive: commons and shared pins at V1, or VDD if static.
// R2: disabled without idle drive: all display pins stay GPIO.
// R3: enabled: multiplexed waveforms, or static when static select set.
// R4: four-bit contrast level, code 0 full VDD, code 15 half VDD.
// R5: static mode switches off contrast and bias control circuits.
// R6: three-bit bias resistor code, 000 disables the ladder.
// R7: 36x8 pattern buffer reached only through index and window registers.
// R8: software writes the index before writing the pattern byte.
// R9: index 0..35 maps to segments; bit n is common n.
// R10: single frame clear: frames repeat until enable cleared.
// R11: single frame set: one frame, done flag, enable self clears.
// R12: software re-enables for each further single frame.
// R13: frame source divided by 16, 32, 64 or 128.
// R14: common count code gives 4, 6, 7 or 8 commons.
// R15: source is 16 kHz RC at 0, 32 kHz crystal at 1.
// R16: software enables the crystal before selecting it.
// R17: 36 segment enable bits; 1 assigns the pin to segment drive.
// R18: index is six bits, upper bits read zero.
// R19: analog config bit 1 blocks digital GPIO on that pin.
// R20: done flag per frame, interrupt if enabled, cleared on accept.
// R21: frame lasts two times commons prescaled clock periods.
// R22: static mode drives pins only 0V or VDD.
// R23: window read returns selected entry unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "slcd_consts.vh"
module slcd_ctrl (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // frame source pins
  input  wire        rc_clk_in,
  input  wire        xtal_clk_in,
  // interrupt handshake
  input  wire        irq_accept,
  output reg         frame_irq,
  // pin drive: one bit per pin in each vector: lcd drive, level, idle at V1, idle at VDD
  output reg  [7:0]  com_active,
  output reg  [35:0] seg_pin_lcd,
  output reg  [35:0] seg_level,
  output reg  [7:0]  com_level,
  output reg  [7:0]  com_idle_v1,
  output reg  [7:0]  com_idle_vdd,
  output reg         static_mode,
  // analog control
  output reg  [3:0]  contrast_level,
  output reg  [2:0]  bias_resistor_select,
  output reg         bias_on,
  output reg  [39:0] analog_only_select
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0]  ctrl_ff;
  reg  [7:0]  mode_ff;
  reg  [7:0]  interrupt_enable_0_ff;
  reg  [7:0]  interrupt_enable_2_ff;
  reg  [35:0] seg_en_ff;
  reg  [5:0]  index_ff;
  reg  [39:0] acfg_ff;
  reg  [7:0]  pat_mem [0:`SLCD_BUF_DEPTH-1];
  integer     j;
  reg         done_ff;
  reg         ap_wr_ff;
  reg  [7:0]  ap_idx_ff;
  wire        en  = ctrl_ff[`SLCD_CTRL_EN];
  wire        stc = ctrl_ff[`SLCD_CTRL_STAT];
  // ----------------------------------------
  // frame source sync (three stages)
  // ----------------------------------------
  wire        rc_lvl;
  wire        xt_lvl;
  reg         src_prev_ff;
  slcd_sync3 rc_sync_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (rc_clk_in),
    .lvl_ff   (rc_lvl)
  );
  slcd_sync3 xt_sync_i (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   (xtal_clk_in),
    .lvl_ff   (xt_lvl)
  );
  // R15 source select
  wire src_sel  = mode_ff[`SLCD_MODE_CKS];
  wire src_lvl  = src_sel ? xt_lvl : rc_lvl;
  wire src_tick = src_lvl & ~src_prev_ff;
  always @(posedge core_clk) begin
    if (!rst_n)
      src_prev_ff <= 1'b0;
    else
      src_prev_ff <= src_lvl;
  end
  // ----------------------------------------
  // prescaler and frame counter
  // ----------------------------------------
  reg  [6:0]  pre_ff;
  reg  [3:0]  step_ff;
  reg  [2:0]  com_ix_ff;
  reg         phase_ff;
  reg  [6:0]  pre_top;
  reg  [3:0]  com_cnt;
  // R13 prescale codes
  always @* begin
    case (ctrl_ff[5:4])
      2'h0:    pre_top = 7'h0f;
      2'h1:    pre_top = 7'h1f;
      2'h2:    pre_top = 7'h3f;
      default: pre_top = 7'h7f;
    endcase
  end
  // R14 common count
  always @* begin
    case (mode_ff[5:4])
      2'h0:    com_cnt = 4'h4;
      2'h1:    com_cnt = 4'h6;
      2'h2:    com_cnt = 4'h7;
      default: com_cnt = 4'h8;
    endcase
  end
  wire pre_tick = src_tick & (pre_ff == pre_top);
  // R21 two periods per common
  // wraps on >= so a smaller common count set mid-frame cannot overrun
  wire frame_end = en & pre_tick & (step_ff >= (com_cnt - 4'h1)) & phase_ff;
  // R10 frames repeat while enabled
  always @(posedge core_clk) begin
    if (!rst_n || !en) begin
      pre_ff    <= 7'h00;
      step_ff   <= 4'h0;
      phase_ff  <= 1'b0;
    end else if (src_tick) begin
      pre_ff <= pre_tick ? 7'h00 : pre_ff + 7'h01;
      if (pre_tick) begin
        phase_ff <= ~phase_ff;
        if (phase_ff)
          step_ff <= (step_ff >= com_cnt - 4'h1) ? 4'h0 : step_ff + 4'h1;
      end
    end
  end
  always @* com_ix_ff = step_ff[2:0];
  // ----------------------------------------
  // ahb-lite slave
  // ----------------------------------------
  wire        ap_valid = hsel & htrans[1] & hready;
  wire [7:0]  ap_idx   = haddr[9:2];
  wire [7:0]  wb       = hwdata[7:0];
  reg  [7:0]  rd_byte;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ap_wr_ff  <= 1'b0;
      ap_idx_ff <= 8'h00;
    end else begin
      ap_wr_ff  <= ap_valid & hwrite;
      ap_idx_ff <= ap_idx;
    end
  end
  // R7 R9 R23 window read
  wire [7:0] win_rd = (index_ff <= `SLCD_BUF_LAST) ? pat_mem[index_ff] : `SLCD_RST_BYTE;
  always @* begin
    case (ap_idx)
      `SLCD_IDX_P3CFG:  rd_byte = acfg_ff[7:0];
      `SLCD_IDX_P4CFG:  rd_byte = acfg_ff[15:8];
      `SLCD_IDX_P5CFG:  rd_byte = acfg_ff[23:16];
      `SLCD_IDX_P6CFG:  rd_byte = acfg_ff[31:24];
      `SLCD_IDX_P7CFG:  rd_byte = acfg_ff[39:32];
      `SLCD_IDX_CTRL:   rd_byte = ctrl_ff;
      `SLCD_IDX_MODE:   rd_byte = mode_ff;
      `SLCD_IDX_SEGEN0: rd_byte = seg_en_ff[7:0];
      `SLCD_IDX_SEGEN1: rd_byte = seg_en_ff[15:8];
      `SLCD_IDX_SEGEN2: rd_byte = seg_en_ff[23:16];
      `SLCD_IDX_SEGEN3: rd_byte = seg_en_ff[31:24];
      `SLCD_IDX_SEGEN4: rd_byte = {4'h0, seg_en_ff[35:32]};
      `SLCD_IDX_WIN:    rd_byte = win_rd;
      // R18 upper bits zero
      `SLCD_IDX_INDEX:  rd_byte = {2'h0, index_ff};
      `SLCD_IDX_INTERRUPT_ENABLE_0:   rd_byte = interrupt_enable_0_ff;
      `SLCD_IDX_INTERRUPT_ENABLE_2:   rd_byte = interrupt_enable_2_ff;
      `SLCD_IDX_IRQ2:   rd_byte = {1'b0, done_ff, 6'h00};
      default:          rd_byte = 8'h00;
    endcase
  end
  // zero wait state: hreadyout never drops, so there is no stall logic
  always @(posedge core_clk) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= (ap_valid & ~hwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_ff   <= `SLCD_RST_BYTE;
      mode_ff   <= `SLCD_RST_BYTE;
      interrupt_enable_0_ff   <= `SLCD_RST_BYTE;
      interrupt_enable_2_ff   <= `SLCD_RST_BYTE;
      seg_en_ff <= 36'h0_0000_0000;
      index_ff  <= 6'h00;
      acfg_ff   <= 40'h00_0000_0000;
    end else begin
      if (ap_wr_ff) begin
        case (ap_idx_ff)
          `SLCD_IDX_P3CFG:  acfg_ff[7:0]      <= wb;
          `SLCD_IDX_P4CFG:  acfg_ff[15:8]     <= wb;
          `SLCD_IDX_P5CFG:  acfg_ff[23:16]    <= wb;
          `SLCD_IDX_P6CFG:  acfg_ff[31:24]    <= wb;
          `SLCD_IDX_P7CFG:  acfg_ff[39:32]    <= wb;
          `SLCD_IDX_CTRL:   ctrl_ff           <= wb;
          `SLCD_IDX_MODE:   mode_ff           <= wb;
          `SLCD_IDX_SEGEN0: seg_en_ff[7:0]    <= wb;
          `SLCD_IDX_SEGEN1: seg_en_ff[15:8]   <= wb;
          `SLCD_IDX_SEGEN2: seg_en_ff[23:16]  <= wb;
          `SLCD_IDX_SEGEN3: seg_en_ff[31:24]  <= wb;
          `SLCD_IDX_SEGEN4: seg_en_ff[35:32]  <= wb[3:0];
          `SLCD_IDX_INDEX:  index_ff          <= wb[5:0];
          `SLCD_IDX_INTERRUPT_ENABLE_0:   interrupt_enable_0_ff           <= wb;
          `SLCD_IDX_INTERRUPT_ENABLE_2:   interrupt_enable_2_ff           <= wb;
          default: ;
        endcase
      end
      // R11 single frame self clear, wins over a same-cycle write
      if (frame_end && mode_ff[`SLCD_MODE_SFM])
        ctrl_ff[`SLCD_CTRL_EN] <= 1'b0;
    end
  end
  // R7 R9 buffer write; out-of-range index ignored
  // cleared at reset so unwritten segments never drive an unknown level
  always @(posedge core_clk) begin
    if (!rst_n) begin
      for (j = 0; j < `SLCD_BUF_DEPTH; j = j + 1)
        pat_mem[j] <= `SLCD_RST_BYTE;
    end else if (ap_wr_ff && ap_idx_ff == `SLCD_IDX_WIN && index_ff <= `SLCD_BUF_LAST) begin
      pat_mem[index_ff] <= wb;
    end
  end
  // ----------------------------------------
  // frame done flag
  // ----------------------------------------
  wire clr_by_sw = ap_wr_ff & (ap_idx_ff == `SLCD_IDX_IRQ2) & ~wb[`SLCD_IRQ2_LCD];
  always @(posedge core_clk) begin
    if (!rst_n)
      done_ff <= 1'b0;
    // R20 set wins over clear
    else if (frame_end)
      done_ff <= 1'b1;
    else if (irq_accept || clr_by_sw)
      done_ff <= 1'b0;
  end
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  reg  [7:0]  nxt_com_act;
  reg  [7:0]  nxt_com_lvl;
  reg  [7:0]  nxt_idle_v1;
  reg  [7:0]  nxt_idle_vdd;
  reg  [35:0] nxt_seg_lcd;
  reg  [35:0] nxt_seg_lvl;
  integer i;
  always @* begin
    nxt_com_act  = 8'h00;
    nxt_com_lvl  = 8'h00;
    nxt_idle_v1  = 8'h00;
    nxt_idle_vdd = 8'h00;
    nxt_seg_lcd  = 36'h0_0000_0000;
    nxt_seg_lvl  = 36'h0_0000_0000;
    for (i = 0; i < 8; i = i + 1) begin
      if (en) begin
        if (i < com_cnt) begin
          // R3 commons active; level toggles with frame phase
          nxt_com_act[i] = 1'b1;
          nxt_com_lvl[i] = (com_ix_ff == i[2:0]) ^ phase_ff;
        end
      end else if (mode_ff[`SLCD_MODE_IDLE]) begin
        // R1 every common and shared pin idles
        nxt_idle_v1[i]  = ~stc;
        nxt_idle_vdd[i] = stc;
      end
      // R2 otherwise gpio
    end
    for (i = 0; i < 36; i = i + 1) begin
      // R17 shared pins used as commons are not segments
      if (en && seg_en_ff[i] && !(i >= 32 && (39 - i) < com_cnt)) begin
        nxt_seg_lcd[i] = 1'b1;
        // R9 R22 lit pixel opposes the selected common
        nxt_seg_lvl[i] = ~pat_mem[i][com_ix_ff] ^ phase_ff;
      end
    end
  end
  always @(posedge core_clk) begin
    if (!rst_n) begin
      com_active           <= 8'h00;
      com_level            <= 8'h00;
      com_idle_v1          <= 8'h00;
      com_idle_vdd         <= 8'h00;
      seg_pin_lcd          <= 36'h0_0000_0000;
      seg_level            <= 36'h0_0000_0000;
      static_mode          <= 1'b0;
      contrast_level       <= 4'h0;
      bias_resistor_select <= 3'h0;
      bias_on              <= 1'b0;
      analog_only_select   <= 40'h00_0000_0000;
      frame_irq            <= 1'b0;
    end else begin
      com_active   <= nxt_com_act;
      com_level    <= nxt_com_lvl;
      com_idle_v1  <= nxt_idle_v1;
      com_idle_vdd <= nxt_idle_vdd;
      seg_pin_lcd  <= nxt_seg_lcd;
      seg_level    <= nxt_seg_lvl;
      // R3 R22 static drive
      static_mode  <= en & stc;
      // R4 R5 contrast off in static mode
      contrast_level       <= stc ? 4'h0 : ctrl_ff[3:0];
      // R5 R6 bias ladder
      bias_resistor_select <= stc ? 3'h0 : mode_ff[2:0];
      bias_on              <= ~stc & (mode_ff[2:0] != 3'h0);
      // R19 analog-only pins
      analog_only_select   <= acfg_ff;
      // R20 interrupt request
      frame_irq <= done_ff & interrupt_enable_2_ff[`SLCD_INTERRUPT_ENABLE_2_LCD];
    end
  end
endmodule // slcd_ctrl

// ----------------------------------------
// three-flop pin synchroniser
// ----------------------------------------
module slcd_sync3 #(
  parameter [0:0] RESET_LVL = 1'b0
) (
  // clock and reset
  input  wire core_clk,
  input  wire rst_n,
  // pin and settled level
  input  wire pin_in,
  output reg  lvl_ff
);
  reg  [2:0] stage_ff;
  // a change counts once stages two and three agree, so a metastable first stage never shows
  always @(posedge core_clk) begin
    if (!rst_n) begin
      stage_ff <= {3{RESET_LVL}};
      lvl_ff   <= RESET_LVL;
    end else begin
      stage_ff <= {stage_ff[1:0], pin_in};
      if (stage_ff[2] == stage_ff[1])
        lvl_ff <= stage_ff[1];
    end
  end
endmodule // slcd_sync3
`default_nettype wire

// ---- sim/slcd_ctrl_checker.sv ----
// Purpose: port assertions for the segment display controller
// Assumes: rst_n synchronous active low, one clock domain
// Notes:   bound into every slcd_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module slcd_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // bus answer
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupt handshake
  input wire logic        irq_accept,
  input wire logic        frame_irq,
  // pin drive and analog
  input wire logic [7:0]  com_active,
  input wire logic [35:0] seg_pin_lcd,
  input wire logic [7:0]  com_idle_v1,
  input wire logic [7:0]  com_idle_vdd,
  input wire logic        static_mode,
  input wire logic [3:0]  contrast_level,
  input wire logic [2:0]  bias_resistor_select,
  input wire logic        bias_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bus_zero_wait: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  a_read_upper_zero: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_idle_all_pins: assert property ((com_idle_v1 == 8'h00 || com_idle_v1 == 8'hff) &&
    (com_idle_vdd == 8'h00 || com_idle_vdd == 8'hff) && !(com_idle_v1[0] && com_idle_vdd[0]))
    else $error("idle drive partial or both levels");
  // idle and enable registers may change on the same edge, so look one cycle in
  a_idle_no_drive: assert property ((com_idle_v1 | com_idle_vdd) != 8'h0 && $past((com_idle_v1 | com_idle_vdd) != 8'h0)
    |-> com_active == 8'h0 && seg_pin_lcd == 36'h0) else $error("display drive during idle");
  a_com_count_code: assert property (com_active inside {8'h00, 8'h0f, 8'h3f, 8'h7f, 8'hff})
    else $error("common set not a legal count");
  a_shared_pin_excl: assert property ((com_active[7:4] &
    {seg_pin_lcd[32], seg_pin_lcd[33], seg_pin_lcd[34], seg_pin_lcd[35]}) == 4'h0) else $error("shared pin doubly driven");
  a_seg_needs_enable: assert property ((seg_pin_lcd != 36'h0 || static_mode) |-> com_active[3:0] == 4'hf)
    else $error("segment drive without commons");
  a_static_analog_off: assert property (static_mode && $past(static_mode) |->
    contrast_level == 4'h0 && bias_resistor_select == 3'h0 && !bias_on) else $error("analog on in static");
  a_accept_clears_irq: assert property (frame_irq && irq_accept |-> ##[1:2] !frame_irq)
    else $error("accept did not clear request");
endmodule // slcd_chk
bind slcd_ctrl slcd_chk slcd_chk_i (.core_clk, .rst_n, .hrdata, .hreadyout, .hresp, .irq_accept, .frame_irq,
  .com_active, .seg_pin_lcd, .com_idle_v1, .com_idle_vdd, .static_mode, .contrast_level,
  .bias_resistor_select, .bias_on);
`default_nettype wire

// ---- sim/slcd_ctrl_tb.sv ----
// Purpose: register and frame tests of the segment display controller
// Assumes: frame sources sped up to 8 and 16 clock periods
// Notes:   bus master waits on hreadyout, watchdog bounds every wait
`timescale 1ns/1ps
`default_nettype none
`include "slcd_consts.vh"
module slcd_ctrl_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, irq_accept = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] src_cnt = 4'h0;
  logic rc_clk_in = 1'b0, xtal_clk_in = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, frame_irq, static_mode, bias_on;
  wire [7:0] com_active, com_level, com_idle_v1, com_idle_vdd;
  wire [35:0] seg_pin_lcd, seg_level;
  wire [3:0] contrast_level;
  wire [2:0] bias_resistor_select;
  wire [39:0] analog_only_select;
  wire [15:0] com0_toggles, seg0_on_com0, seg0_on_com2;
  int failures = 0, tests_run = 0, n, p;
  logic [7:0] regs [16] = '{`SLCD_IDX_P3CFG, `SLCD_IDX_P4CFG, `SLCD_IDX_CTRL, `SLCD_IDX_MODE, `SLCD_IDX_SEGEN0,
    `SLCD_IDX_WIN, `SLCD_IDX_INDEX, `SLCD_IDX_SEGEN1, `SLCD_IDX_SEGEN2, `SLCD_IDX_SEGEN3, `SLCD_IDX_SEGEN4,
    `SLCD_IDX_P5CFG, `SLCD_IDX_P6CFG, `SLCD_IDX_P7CFG, `SLCD_IDX_INTERRUPT_ENABLE_2, 8'h10};
  logic [7:0] cfg [5] = '{`SLCD_IDX_P3CFG, `SLCD_IDX_P4CFG, `SLCD_IDX_P5CFG, `SLCD_IDX_P6CFG, `SLCD_IDX_P7CFG};
  logic [7:0] pidx [3] = '{8'h00, 8'h23, 8'h24};
  logic [7:0] cm [4] = '{8'h0f, 8'h3f, 8'h7f, 8'hff};
  logic [3:0] sh [4] = '{4'hf, 4'h3, 4'h1, 4'h0};
  slcd_ctrl slcd_ctrl_i (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .rc_clk_in, .xtal_clk_in, .irq_accept, .frame_irq, .com_active, .seg_pin_lcd,
    .seg_level, .com_level, .com_idle_v1, .com_idle_vdd, .static_mode, .contrast_level, .bias_resistor_select,
    .bias_on, .analog_only_select);
  slcd_panel slcd_panel_i (.core_clk, .rst_n, .com_active, .com_level, .seg0_active(seg_pin_lcd[0]),
    .seg0_level(seg_level[0]), .com0_toggles, .seg0_on_com0, .seg0_on_com2);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    src_cnt <= src_cnt + 4'h1;
    rc_clk_in <= src_cnt[2];
    xtal_clk_in <= src_cnt[3];
  end
  // ----------------------------------------
  // bus tasks and checks
  // ----------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {22'h0, idx, 2'h0};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, wd};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h0, exp});
  endtask
  task automatic settle;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic wait_irq;
    n = 0;
    while (frame_irq !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  task automatic accept;
    irq_accept <= 1'b1;
    @(posedge core_clk);
    irq_accept <= 1'b0;
    settle;
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000000;
    failures++;
    close_out;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    foreach (cfg[k]) wr(cfg[k], 8'h01 << k);
    settle;
    check(analog_only_select, 40'h1008040201);
    wr(`SLCD_IDX_INDEX, 8'hff);
    rdchk(`SLCD_IDX_INDEX, 8'h3f);
    wr(`SLCD_IDX_SEGEN4, 8'hff);
    rdchk(`SLCD_IDX_SEGEN4, 8'h0f);
    foreach (pidx[i]) begin
      wr(`SLCD_IDX_INDEX, pidx[i]);
      wr(`SLCD_IDX_WIN, 8'hc3 ^ pidx[i]);
    end
    foreach (pidx[i]) begin
      wr(`SLCD_IDX_INDEX, pidx[i]);
      rdchk(`SLCD_IDX_WIN, i == 2 ? 8'h00 : 8'hc3 ^ pidx[i]);
      rdchk(`SLCD_IDX_WIN, i == 2 ? 8'h00 : 8'hc3 ^ pidx[i]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`SLCD_IDX_CTRL, {1'b0, s[1], 6'h0});
      wr(`SLCD_IDX_MODE, {s[0], 7'h0});
      settle;
      check({com_idle_v1, com_idle_vdd}, {s == 1 ? 8'hff : 8'h00, s == 3 ? 8'hff : 8'h00});
    end
    wr(`SLCD_IDX_SEGEN0, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(`SLCD_IDX_MODE, {2'b00, c[1:0], 1'b0, 3'h3});
      wr(`SLCD_IDX_CTRL, 8'h85);
      settle;
      check({com_active, seg_pin_lcd[35:32], seg_pin_lcd[0]}, {cm[c], sh[c], 1'b1});
      check({static_mode, contrast_level, bias_resistor_select, bias_on}, {1'b0, 4'h5, 3'h3, 1'b1});
    end
    for (int b = 0; b < 8; b++) begin
      wr(`SLCD_IDX_MODE, {5'h00, b[2:0]});
      settle;
      check(bias_resistor_select, b[2:0]);
    end
    wr(`SLCD_IDX_CTRL, 8'h8f);
    settle;
    check(contrast_level, 4'hf);
    wr(`SLCD_IDX_CTRL, 8'hc5);
    settle;
    check({static_mode, contrast_level, bias_on, com_active[3:0]}, {1'b1, 4'h0, 1'b0, 4'hf});
    wr(`SLCD_IDX_CTRL, 8'h00);
    wr(`SLCD_IDX_IRQ2, 8'h00);
    wr(`SLCD_IDX_INTERRUPT_ENABLE_2, 8'h40);
    wr(`SLCD_IDX_MODE, 8'h00);
    wr(`SLCD_IDX_CTRL, 8'h80);
    wait_irq;
    accept;
    wait_irq;
    check(n > 900, 1);
    rdchk(`SLCD_IDX_CTRL, 8'h80);
    check(com0_toggles != 16'h0, 1);
    check(seg0_on_com0 != 16'h0, 1);
    check(seg0_on_com2, 16'h0);
    wr(`SLCD_IDX_CTRL, 8'h00);
    accept;
    for (int k = 0; k < 4; k++) begin
      wr(`SLCD_IDX_MODE, {2'b01, 2'h0, k[0], 3'h0});
      wr(`SLCD_IDX_CTRL, {2'b10, k[1:0], 4'h0});
      wait_irq;
      p = k[0] ? 16 : 8;
      check(n >= (112 << k) * p && n <= ((128 << k) + 2) * p, 1);
      rdchk(`SLCD_IDX_CTRL, {2'b00, k[1:0], 4'h0});
      check({com_active, frame_irq}, 9'h001);
      accept;
      check(frame_irq, 1'b0);
    end
    close_out;
  end
endmodule // slcd_ctrl_tb
`default_nettype wire

// ---- sim/slcd_panel.sv ----
// Purpose: glass panel model watching common 0
// Assumes: panel only loads the pins, drives nothing back
// Notes:   counts level changes seen while the common is driven
`timescale 1ns/1ps
`default_nettype none
module slcd_panel (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // pin drive
  input wire logic [7:0]  com_active,
  input wire logic [7:0]  com_level,
  input wire logic        seg0_active,
  input wire logic        seg0_level,
  // observation
  output logic     [15:0] com0_toggles,
  output logic     [15:0] seg0_on_com0,
  output logic     [15:0] seg0_on_com2
);
  logic prev_ff;
  logic sel0;
  logic sel2;
  // a common is selected when its level differs from two others
  assign sel0 = com_level[0] != com_level[1] && com_level[0] != com_level[2];
  assign sel2 = com_level[2] != com_level[0] && com_level[2] != com_level[3];
  always @(posedge core_clk) begin
    prev_ff <= com_level[0];
    if (!rst_n) begin
      com0_toggles <= 16'h0;
      seg0_on_com0 <= 16'h0;
      seg0_on_com2 <= 16'h0;
    end else begin
      if (com_active[0] && com_level[0] != prev_ff)
        com0_toggles <= com0_toggles + 16'h1;
      // pixel lit while segment opposes the selected common
      if (com_active[0] && seg0_active && sel0 && seg0_level != com_level[0])
        seg0_on_com0 <= seg0_on_com0 + 16'h1;
      if (com_active[2] && seg0_active && sel2 && seg0_level != com_level[2])
        seg0_on_com2 <= seg0_on_com2 + 16'h1;
    end
  end
endmodule // slcd_panel
`default_nettype wire
